// file: blink_tick_gen.sv
// Tick generator giving one pulse every CYCLES clock cycles.
// Assumes a free-running clock and a clock enable that freezes it.
`include "lamp_defs.svh"

module blink_tick_gen #(
   parameter int unsigned CYCLES = `BLINK_TICK_CYCLES
) (
   input  wire logic clk_in,
   input  wire logic reset_n_in,
   input  wire logic ce_in,
   output logic      tick_out
);
   import lamp_pkg::*;

   localparam logic [`TICK_CNT_W-1:0] LAST = `TICK_CNT_W'(CYCLES - 1);

   tick_state_t st_r;
   tick_state_t st_nxt;

   // ------------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------------
   // Count up through the period and pulse at its end.
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (st_r.count == LAST) begin
         st_nxt.count = '0;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.count = st_r.count + `TICK_CNT_W'(1);
      end
   end

   // Register the state; a low clock enable holds it.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_r <= '0;
      end else if (ce_in) begin
         st_r <= st_nxt;
      end
   end

   assign tick_out = st_r.tick;

endmodule // blink_tick_gen

// file: expansion_card_status_lamps.sv
// Status lamp logic for drive expansion cards, with a Wishbone register file.
// Assumes a classic Wishbone master on clk_in and asynchronous pin inputs.
`include "lamp_defs.svh"

module expansion_card_status_lamps #(
   parameter int unsigned BLINK_TICK_CYCLES = `BLINK_TICK_CYCLES
) (
   input  wire logic                  clk_in,
   input  wire logic                  reset_n_in,
   input  wire logic                  ce_in,
   input  wire logic                  wb_cyc_in,
   input  wire logic                  wb_stb_in,
   input  wire logic                  wb_we_in,
   input  wire logic [`WB_ADDR_W-1:0] wb_adr_in,
   input  wire logic [31:0]           wb_dat_in,
   input  wire logic [3:0]            wb_sel_in,
   output logic      [31:0]           wb_dat_out,
   output logic                       wb_ack_out,
   output logic                       irq_out,
   input  wire logic                  digital_input_one_in,
   input  wire logic                  digital_input_two_in,
   output logic                       relay_output_five_out,
   output logic                       relay_output_six_out,
   output logic                       relay_output_seven_out,
   output logic                       relay_output_eight_out,
   output logic                       relay_output_nine_out,
   output logic                       relay_output_ten_out,
   output logic      [5:0]            relay_lamp_out,
   output logic                       link_state_lamp_out,
   output logic                       online_lamp_out,
   output logic                       offline_fault_lamp_out
);
   import lamp_pkg::*;

   state_t      st_r;
   state_t      st_nxt;
   logic        tick;
   logic        req;
   logic        wr;
   logic [1:0]  edges;
   logic [1:0]  clr;
   fault_lamp_t fmode;

   // ------------------------------------------------------------------------
   // Blink time base
   // ------------------------------------------------------------------------
   // One tick every 125 ms drives the four-bit blink phase counter.
   blink_tick_gen #(
      .CYCLES   (BLINK_TICK_CYCLES)
   ) u_tick (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .ce_in      (ce_in),
      .tick_out   (tick)
   );

   // ------------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      fmode = FL_DARK;

      // Two-stage synchronisers, then an edge detector on the second stage.
      st_nxt.in_sync1 = {digital_input_two_in, digital_input_one_in};
      st_nxt.in_sync2 = st_r.in_sync1;
      st_nxt.in_prev = st_r.in_sync2;
      edges = st_r.in_sync2 ^ st_r.in_prev;

      // Advance the blink phase on each time-base tick.
      if (tick) begin
         st_nxt.phase = st_r.phase + 4'h1;
      end

      // Bus handshake: ack one cycle after the request, then drop it.
      req = wb_cyc_in & wb_stb_in;
      st_nxt.ack = req & ~st_r.ack;
      wr = req & wb_we_in & st_r.ack & wb_sel_in[0];
      clr = 2'h0;
      if (wr) begin
         case (wb_adr_in)
            `ADDR_CTRL: begin
               st_nxt.link_mode =
                  link_mode_t'(wb_dat_in[`CTRL_LINK_HI:`CTRL_LINK_LO]);
               st_nxt.online = wb_dat_in[`CTRL_ONLINE];
               st_nxt.offline = wb_dat_in[`CTRL_OFFLINE];
               st_nxt.diag_en = wb_dat_in[`CTRL_DIAG_EN];
               st_nxt.cfg_len_err = wb_dat_in[`CTRL_CFG_LEN_ERR];
               st_nxt.param_err = wb_dat_in[`CTRL_PARAM_ERR];
               st_nxt.asic_err = wb_dat_in[`CTRL_ASIC_ERR];
            end
            // Relay commands come from software, which must pace them slowly.
            `ADDR_RELAY: begin
               st_nxt.relay = wb_dat_in[5:0];
            end
            `ADDR_IRQ_STAT: begin
               clr = wb_dat_in[1:0];
            end
            `ADDR_IRQ_MASK: begin
               st_nxt.irq_mask = wb_dat_in[1:0];
            end
            default: begin
            end
         endcase
      end

      // Sticky input-edge flags; a new edge wins over a clear.
      st_nxt.irq_stat = (st_r.irq_stat & ~clr) | edges;
      st_nxt.irq = |(st_r.irq_stat & st_r.irq_mask);

      // Read data is prepared together with the ack; zero otherwise.
      st_nxt.rdata = `RDATA_ZERO;
      if (req & ~st_r.ack & ~wb_we_in) begin
         case (wb_adr_in)
            `ADDR_CTRL: begin
               st_nxt.rdata[7:0] = {st_r.asic_err, st_r.param_err,
                                    st_r.cfg_len_err, st_r.diag_en,
                                    st_r.offline, st_r.online,
                                    st_r.link_mode};
            end
            `ADDR_RELAY: begin
               st_nxt.rdata[5:0] = st_r.relay;
            end
            `ADDR_INPUTS: begin
               st_nxt.rdata[4:0] = {st_r.offline_lamp, st_r.online_lamp,
                                    st_r.link_lamp, st_r.in_sync2};
            end
            `ADDR_IRQ_STAT: begin
               st_nxt.rdata[1:0] = st_r.irq_stat;
            end
            `ADDR_IRQ_MASK: begin
               st_nxt.rdata[1:0] = st_r.irq_mask;
            end
            default: begin
            end
         endcase
      end

      // Connection lamp: steady while joining, blinking when up, else dark.
      case (st_r.link_mode)
         LINK_JOINING: st_nxt.link_lamp = 1'b1;
         LINK_UP:      st_nxt.link_lamp = ~st_r.phase[`PH_1HZ];
         default:      st_nxt.link_lamp = 1'b0;
      endcase

      // Online lamp follows the online state.
      st_nxt.online_lamp = st_r.online;

      // Offline/fault pattern: one rate only, highest priority first.
      if (!st_r.diag_en) begin
         fmode = FL_DARK;
      end else if (st_r.asic_err) begin
         fmode = FL_4HZ;
      end else if (st_r.param_err) begin
         fmode = FL_2HZ;
      end else if (st_r.cfg_len_err) begin
         fmode = FL_1HZ;
      end else if (st_r.offline) begin
         fmode = FL_STEADY;
      end else begin
         fmode = FL_HALF_HZ;
      end
      case (fmode)
         FL_STEADY:  st_nxt.offline_lamp = 1'b1;
         FL_HALF_HZ: st_nxt.offline_lamp = ~st_r.phase[`PH_HALF_HZ];
         FL_1HZ:     st_nxt.offline_lamp = ~st_r.phase[`PH_1HZ];
         FL_2HZ:     st_nxt.offline_lamp = ~st_r.phase[`PH_2HZ];
         FL_4HZ:     st_nxt.offline_lamp = ~st_r.phase[`PH_4HZ];
         default:    st_nxt.offline_lamp = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------------
   // Reset clears all state; a low clock enable freezes it.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_r <= '0;
         st_r.relay <= `RELAY_RESET;
         st_r.irq_mask <= `MASK_RESET;
      end else if (ce_in) begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------------------
   // Outputs, all straight from state flip-flops
   // ------------------------------------------------------------------------
   // Relay lamps and relay outputs share the relay command flops.
   assign relay_lamp_out = st_r.relay;
   assign relay_output_five_out = st_r.relay[0];
   assign relay_output_six_out = st_r.relay[1];
   assign relay_output_seven_out = st_r.relay[2];
   assign relay_output_eight_out = st_r.relay[3];
   assign relay_output_nine_out = st_r.relay[4];
   assign relay_output_ten_out = st_r.relay[5];
   assign link_state_lamp_out = st_r.link_lamp;
   assign online_lamp_out = st_r.online_lamp;
   assign offline_fault_lamp_out = st_r.offline_lamp;
   assign wb_dat_out = st_r.rdata;
   assign wb_ack_out = st_r.ack;
   assign irq_out = st_r.irq;

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   // A relay write shows on the relay lamps and on relay output ten.
   property p_relay_lamp;
      @(posedge clk_in) disable iff (!reset_n_in)
      (ce_in && wr && wb_adr_in == `ADDR_RELAY)
      |=> (relay_lamp_out == $past(wb_dat_in[5:0]))
          && (relay_output_ten_out == $past(wb_dat_in[5]));
   endproperty
   a_relay_lamp: assert property (p_relay_lamp)
      else $error("relay lamp does not follow relay command");

   // Joining holds the connection lamp lit.
   property p_link_joining;
      @(posedge clk_in) disable iff (!reset_n_in)
      (ce_in && st_r.link_mode == LINK_JOINING) |=> link_state_lamp_out;
   endproperty
   a_link_joining: assert property (p_link_joining)
      else $error("connection lamp dark while joining");

   // Link up blinks the lamp from the 1 Hz phase bit.
   property p_link_up;
      @(posedge clk_in) disable iff (!reset_n_in)
      (ce_in && st_r.link_mode == LINK_UP)
      |=> link_state_lamp_out == !$past(st_r.phase[`PH_1HZ]);
   endproperty
   a_link_up: assert property (p_link_up)
      else $error("connection lamp not blinking at 1 Hz");

   // No link keeps the connection lamp dark.
   property p_link_down;
      @(posedge clk_in) disable iff (!reset_n_in)
      (ce_in && st_r.link_mode == LINK_DOWN) |=> !link_state_lamp_out;
   endproperty
   a_link_down: assert property (p_link_down)
      else $error("connection lamp lit without link");

   // A settled input level reaches the synchronised copy within three cycles.
   property p_input_capture;
      @(posedge clk_in) disable iff (!reset_n_in)
      ($rose(digital_input_one_in)
       ##0 (ce_in && digital_input_one_in) [*3]) |=> st_r.in_sync2[0];
   endproperty
   a_input_capture: assert property (p_input_capture)
      else $error("digital input rise not captured");

   // Online lamp mirrors the online state one cycle later.
   property p_online;
      @(posedge clk_in) disable iff (!reset_n_in)
      ce_in |=> online_lamp_out == $past(st_r.online);
   endproperty
   a_online: assert property (p_online)
      else $error("online lamp disagrees with online state");

   // Offline without faults lights the lamp steadily.
   property p_offline_steady;
      @(posedge clk_in) disable iff (!reset_n_in)
      (ce_in && st_r.diag_en && st_r.offline && !st_r.asic_err
       && !st_r.param_err && !st_r.cfg_len_err) |=> offline_fault_lamp_out;
   endproperty
   a_offline_steady: assert property (p_offline_steady)
      else $error("offline lamp not steady while offline");

   // Not offline and no faults: the slow blink.
   property p_not_offline;
      @(posedge clk_in) disable iff (!reset_n_in)
      (ce_in && st_r.diag_en && !st_r.offline && !st_r.asic_err
       && !st_r.param_err && !st_r.cfg_len_err)
      |=> offline_fault_lamp_out == !$past(st_r.phase[`PH_HALF_HZ]);
   endproperty
   a_not_offline: assert property (p_not_offline)
      else $error("offline lamp not blinking while not offline");

   // Length mismatch alone gives the 1 Hz blink.
   property p_cfg_len;
      @(posedge clk_in) disable iff (!reset_n_in)
      (ce_in && st_r.diag_en && st_r.cfg_len_err && !st_r.param_err
       && !st_r.asic_err)
      |=> offline_fault_lamp_out == !$past(st_r.phase[`PH_1HZ]);
   endproperty
   a_cfg_len: assert property (p_cfg_len)
      else $error("offline lamp not at 1 Hz on length error");

   // Parameter error outranks the length error with 2 Hz.
   property p_param;
      @(posedge clk_in) disable iff (!reset_n_in)
      (ce_in && st_r.diag_en && st_r.param_err && !st_r.asic_err)
      |=> offline_fault_lamp_out == !$past(st_r.phase[`PH_2HZ]);
   endproperty
   a_param: assert property (p_param)
      else $error("offline lamp not at 2 Hz on parameter error");

   // Interface start-up failure outranks every other fault with 4 Hz.
   property p_asic;
      @(posedge clk_in) disable iff (!reset_n_in)
      (ce_in && st_r.diag_en && st_r.asic_err)
      |=> offline_fault_lamp_out == !$past(st_r.phase[`PH_4HZ]);
   endproperty
   a_asic: assert property (p_asic)
      else $error("offline lamp not at 4 Hz on start-up failure");

   // Diagnosis off darkens the lamp whatever the faults.
   property p_diag_off;
      @(posedge clk_in) disable iff (!reset_n_in)
      (ce_in && !st_r.diag_en) |=> !offline_fault_lamp_out;
   endproperty
   a_diag_off: assert property (p_diag_off)
      else $error("offline lamp lit with diagnosis disabled");

endmodule // expansion_card_status_lamps

// file: field_side_model.sv
// Model of the field wiring in front of the card: the two digital input pins.
// Assumes the bench calls toggle() from its main sequence on clk_in.
module field_side_model #(
   parameter int HALF = 12500
) (
   input  wire logic clk_in,
   output logic      din_one_out,
   output logic      din_two_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------------
   // Both pins rest low from time zero. Only data pins are modelled: like an
   // ordinary fieldbus setup, the far side steers no send-request line.
   initial begin
      din_one_out = 1'b0;
      din_two_out = 1'b0;
   end

   // Flips one pin, then holds it for a full 1 kHz half period.
   task automatic toggle(input int which);
      @(posedge clk_in);
      if (which == 0) begin
         din_one_out <= ~din_one_out;
      end else begin
         din_two_out <= ~din_two_out;
      end
      repeat (HALF) @(posedge clk_in);
   endtask
endmodule // field_side_model

// file: lamp_defs.svh
// Constants for the expansion card status lamp block.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone bus.
`ifndef LAMP_DEFS_SVH
`define LAMP_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS     40
`define BLINK_TICK_NS     125000000
`define BLINK_TICK_CYCLES ((`BLINK_TICK_NS) / (`CLK_PERIOD_NS))
`define TICK_CNT_W        24

// ----------------------------------------------------------------------------
// Blink phase bits: each bit toggles at half the rate of the one below.
// ----------------------------------------------------------------------------
`define PH_4HZ            0
`define PH_2HZ            1
`define PH_1HZ            2
`define PH_HALF_HZ        3

// ----------------------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------------------
`define WB_ADDR_W         8
`define ADDR_CTRL         8'h00
`define ADDR_RELAY        8'h04
`define ADDR_INPUTS       8'h08
`define ADDR_IRQ_STAT     8'h0C
`define ADDR_IRQ_MASK     8'h10
`define CTRL_LINK_HI      1
`define CTRL_LINK_LO      0
`define CTRL_ONLINE       2
`define CTRL_OFFLINE      3
`define CTRL_DIAG_EN      4
`define CTRL_CFG_LEN_ERR  5
`define CTRL_PARAM_ERR    6
`define CTRL_ASIC_ERR     7
`define RELAY_RESET       6'h00
`define MASK_RESET        2'h0
`define RDATA_ZERO        32'h0000_0000

`endif

// file: lamp_pkg.sv
// Types for the expansion card status lamp block.
// Assumes lamp_defs.svh is on the include path.
`include "lamp_defs.svh"

package lamp_pkg;

   // Connection state toward the control board, written by software.
   typedef enum logic [1:0] {
      LINK_DOWN    = 2'b00,
      LINK_JOINING = 2'b01,
      LINK_UP      = 2'b10,
      LINK_SPARE   = 2'b11
   } link_mode_t;

   // Pattern chosen for the offline/fault lamp.
   typedef enum logic [2:0] {
      FL_DARK    = 3'b000,
      FL_STEADY  = 3'b001,
      FL_HALF_HZ = 3'b010,
      FL_1HZ     = 3'b011,
      FL_2HZ     = 3'b100,
      FL_4HZ     = 3'b101
   } fault_lamp_t;

   // State of the tick generator.
   typedef struct packed {
      logic [`TICK_CNT_W-1:0] count;
      logic                   tick;
   } tick_state_t;

   // Whole state of the lamp block.
   typedef struct packed {
      link_mode_t  link_mode;
      logic        online;
      logic        offline;
      logic        diag_en;
      logic        cfg_len_err;
      logic        param_err;
      logic        asic_err;
      logic [5:0]  relay;
      logic [1:0]  irq_stat;
      logic [1:0]  irq_mask;
      logic [1:0]  in_sync1;
      logic [1:0]  in_sync2;
      logic [1:0]  in_prev;
      logic [3:0]  phase;
      logic        link_lamp;
      logic        online_lamp;
      logic        offline_lamp;
      logic        ack;
      logic [31:0] rdata;
      logic        irq;
   } state_t;

endpackage

// file: tb_top.sv
// Self-checking bench for the status lamp block, driven over Wishbone.
// Assumes lamp_defs.svh on the include path and a short blink tick.
`include "lamp_defs.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------------
   localparam int TICK = 4;
   logic        clk_in = 1'b0, reset_n_in = 1'b0, ce = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0000_0000, rdat, q;
   logic [3:0]  sel = 4'hF;
   logic [5:0]  ro, rl;
   logic        ack, irq, link_l, onl_l, off_l, d1, d2;
   int          num_errors = 0, n_tests = 0, cyc_cnt = 0;

   expansion_card_status_lamps #(.BLINK_TICK_CYCLES(TICK)) i_dut (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
      .wb_dat_in(dat), .wb_sel_in(sel), .wb_dat_out(rdat),
      .wb_ack_out(ack), .irq_out(irq),
      .digital_input_one_in(d1), .digital_input_two_in(d2),
      .relay_output_five_out(ro[0]), .relay_output_six_out(ro[1]),
      .relay_output_seven_out(ro[2]), .relay_output_eight_out(ro[3]),
      .relay_output_nine_out(ro[4]), .relay_output_ten_out(ro[5]),
      .relay_lamp_out(rl), .link_state_lamp_out(link_l),
      .online_lamp_out(onl_l), .offline_fault_lamp_out(off_l));

   field_side_model #(.HALF(12500)) i_field (
      .clk_in(clk_in), .din_one_out(d1), .din_two_out(d2));

   // Clock at 25 MHz and a cycle ceiling that cuts a hang short.
   always #20 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc_cnt++;
      if (cyc_cnt == 90000) begin
         num_errors++;
         print_verdict();
      end
   end

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   // Counts a comparison and reports a mismatch.
   task automatic check(input string nm, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   // One classic cycle: the request stands until ack is sampled high at a
   // rising edge; read data is taken and the request dropped at that edge.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_in);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
      do begin
         @(posedge clk_in);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) check("ack", 32'(ack), 32'h1);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 4'hF);
      repeat (3) @(posedge clk_in);
   endtask

   function automatic logic lamp(input int w);
      return (w == 0) ? link_l : off_l;
   endfunction

   // Lamp must stay at one level for a number of cycles.
   task automatic hold(input int w, input logic v, input string nm);
      logic ok;
      ok = 1'b1;
      repeat (80) begin
         @(negedge clk_in);
         if (lamp(w) !== v) ok = 1'b0;
      end
      check(nm, 32'(ok), 32'h1);
   endtask

   // Measures two half periods of a blinking lamp in cycles.
   task automatic blink(input int w, input int half, input string nm);
      logic v;
      int   n;
      for (int k = 0; k < 3; k++) begin
         v = lamp(w);
         n = 0;
         while (lamp(w) === v && n < 300) begin
            @(negedge clk_in);
            n++;
         end
         if (k > 0) check(nm, 32'(n), 32'(half));
      end
   endtask

   // Sets the control word and judges the offline/fault lamp.
   task automatic fault(input logic [7:0] c, input int half);
      wr(`ADDR_CTRL, {24'h0, c});
      if (half > 0) blink(1, half, "fault_blink");
      else hold(1, (half < 0), "fault_steady");
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset();
      check("outputs", 32'({ro, rl, link_l, onl_l, off_l, irq}), 32'h0);
      xfer(1'b0, `ADDR_CTRL, 32'h0, 4'hF);
      check("ctrl_rst", q, 32'h0);
      xfer(1'b1, 8'h14, 32'hFF, 4'hF);
      xfer(1'b0, 8'h14, 32'h0, 4'hF);
      check("unmapped", q, 32'h0);
   endtask

   task automatic t_relays();
      for (int i = 0; i < 6; i++) begin
         wr(`ADDR_RELAY, 32'h1 << i);
         check("relay", {26'h0, ro}, 32'h1 << i);
         check("relay_lamp", {26'h0, rl}, 32'h1 << i);
      end
      xfer(1'b1, `ADDR_RELAY, 32'h3F, 4'hE);
      check("sel_off", {26'h0, rl}, 32'h20);
      wr(`ADDR_RELAY, 32'h0);
      check("relay_open", {26'h0, rl}, 32'h0);
   endtask

   task automatic t_link();
      wr(`ADDR_CTRL, 32'h1);
      hold(0, 1'b1, "joining");
      wr(`ADDR_CTRL, 32'h2);
      blink(0, 4 * TICK, "linked");
      wr(`ADDR_CTRL, 32'h0);
      hold(0, 1'b0, "down");
      wr(`ADDR_CTRL, 32'h3);
      hold(0, 1'b0, "spare");
      wr(`ADDR_CTRL, 32'h4);
      check("online", 32'(onl_l), 32'h1);
      wr(`ADDR_CTRL, 32'h0);
      check("not_online", 32'(onl_l), 32'h0);
   endtask

   // A low clock enable freezes the blink, which resumes at full rate.
   task automatic t_freeze();
      logic v;
      wr(`ADDR_CTRL, 32'h2);
      @(posedge clk_in);
      ce <= 1'b0;
      @(posedge clk_in);
      v = link_l;
      hold(0, v, "frozen");
      @(posedge clk_in);
      ce <= 1'b1;
      blink(0, 4 * TICK, "thawed");
      wr(`ADDR_CTRL, 32'h0);
      hold(0, 1'b0, "down_again");
   endtask

   task automatic t_faults();
      fault(8'h18, -1);
      fault(8'h10, 8 * TICK);
      fault(8'h30, 4 * TICK);
      fault(8'h50, 2 * TICK);
      fault(8'h90, TICK);
      fault(8'hF0, TICK);
      fault(8'h70, 2 * TICK);
      fault(8'hE8, 0);
   endtask

   task automatic t_inputs();
      for (int i = 0; i < 4; i++) begin
         i_field.toggle(i / 2);
         xfer(1'b0, `ADDR_INPUTS, 32'h0, 4'hF);
         check("inputs", {30'h0, q[1:0]}, (i % 2 == 0) ? (i / 2 + 1) : 0);
      end
      xfer(1'b0, `ADDR_IRQ_STAT, 32'h0, 4'hF);
      check("irq_stat", q, 32'h3);
      check("irq_masked", 32'(irq), 32'h0);
      wr(`ADDR_IRQ_MASK, 32'h2);
      check("irq_on", 32'(irq), 32'h1);
      wr(`ADDR_IRQ_STAT, 32'h2);
      check("irq_clear", 32'(irq), 32'h0);
      xfer(1'b0, `ADDR_IRQ_STAT, 32'h0, 4'hF);
      check("irq_left", q, 32'h1);
   endtask

   // ------------------------------------------------------------------
   // Main sequence and verdict
   // ------------------------------------------------------------------
   task automatic print_verdict();
      if (num_errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge clk_in);
      reset_n_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      t_reset();
      t_relays();
      t_link();
      t_freeze();
      t_faults();
      t_inputs();
      print_verdict();
   end
endmodule // tb_top
